/* File: src/cogp_clock_gate.sv */
`timescale 1ns/1ps
`default_nettype none
module cogp_clock_gate
	import cogp_pkg::*;
#(
	parameter int unsigned WAKE_CYC = PD_WAKE_DEF // Power-up latency in system cycles
) (
	input  wire logic  clk_sys_i,
	input  wire logic  sys_rst_i,
	input  wire logic  clk_en_i,
	input  wire logic  pm_mode_i,
	input  wire logic  out_enable_i,
	input  wire logic  halt_proc_n_i,
	input  wire logic  halt_bus_n_i,
	input  wire logic  power_down_n_i,
	input  wire logic  crystal_input_i,
	input  wire logic  ser_clk_i,
	input  wire logic  ser_data_i,
	output logic       ser_data_o,
	output logic       ser_data_oe_o,
	output cogp_clk_t  clocks_o,
	output logic       clocks_oe_o,
	output cogp_ssc_t  ssc_cfg_o,
	output logic       osc_run_o
);

	localparam int unsigned CW = $clog2(WAKE_CYC) + 1;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [NUM_PINS-1:0] pins_raw;  // All pins from outside the clock domain
	logic [NUM_PINS-1:0] sync1;     // First stage, read only by sync2
	logic [NUM_PINS-1:0] sync2;
	logic [NUM_PINS-1:0] sync3;
	logic [NUM_PINS-1:0] filt;      // Level once stages two and three agree
	logic [NUM_PINS-1:0] filt_q;    // One cycle older, for edge finding

	assign pins_raw = {ser_data_i, ser_clk_i, crystal_input_i, pm_mode_i,
		out_enable_i, power_down_n_i, halt_bus_n_i, halt_proc_n_i};

	// Three-stage chain on every pin
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			sync1 <= PIN_RST;
			sync2 <= PIN_RST;
			sync3 <= PIN_RST;
			filt_q <= PIN_RST;
		end else if (clk_en_i) begin
			sync1 <= pins_raw;
			sync2 <= sync1;
			sync3 <= sync2;
			filt_q <= filt;
		end
	end

	// Agreement filter: a change counts only when two stages match
	for (genvar g = 0; g < NUM_PINS; g++) begin : g_filt
		always_ff @(posedge clk_sys_i) begin
			if (sys_rst_i) begin
				filt[g] <= PIN_RST[g];
			end else if (clk_en_i && (sync2[g] == sync3[g])) begin
				filt[g] <= sync3[g];
			end
		end
	end

	// ****************************************************************
	// Power-management qualifiers
	// ****************************************************************
	logic pm_on;          // Management pins honoured
	logic halt_proc_act;  // Processor group to be stopped
	logic halt_bus_act;   // Gated bus group to be stopped
	logic pd_req;         // Power-down requested

	assign pm_on         = ~filt[PIN_MODE];
	assign halt_proc_act = pm_on & ~filt[PIN_HALT_PROC];
	assign halt_bus_act  = pm_on & ~filt[PIN_HALT_BUS];
	assign pd_req        = pm_on & ~filt[PIN_PD_N];

	// ****************************************************************
	// Power-down sequencer
	// ****************************************************************
	cogp_pd_t        pd_state;  // Sequencer state
	logic [CW-1:0]   pd_cnt;    // Drain and wake counter
	logic            pd_gate;   // All outputs gated off
	logic            osc_run;   // Oscillator and dividers running

	assign pd_gate = (pd_state != PD_RUN);
	assign osc_run = (pd_state != PD_DOWN);

	// Drain to low, stop, then wait out the restart latency
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			pd_state <= PD_RUN;
			pd_cnt <= '0;
		end else if (clk_en_i) begin
			case (pd_state)
				PD_RUN: begin
					pd_cnt <= '0;
					if (pd_req) begin
						pd_state <= PD_DRAIN;
					end
				end
				PD_DRAIN: begin
					pd_cnt <= pd_cnt + CW'(1);
					if (pd_cnt == CW'(PD_DRAIN_SYS - 1)) begin
						pd_state <= PD_DOWN;
						pd_cnt <= '0;
					end
				end
				PD_DOWN: begin
					// Halt pins are ignored from here until wake-up
					if (!pd_req) begin
						pd_state <= PD_WAKE;
					end
				end
				default: begin
					// Dividers run but outputs stay low until settled
					pd_cnt <= pd_cnt + CW'(1);
					if (pd_cnt == CW'(WAKE_CYC - 1)) begin
						pd_state <= PD_RUN;
					end
				end
			endcase
		end
	end

	// ****************************************************************
	// Serial configuration port
	// ****************************************************************
	logic [7:0]  regs [NUM_BYTES];  // Configuration bytes
	cogp_ser_t   ser_state;         // Byte engine state
	logic [3:0]  bitc;              // Bits seen in the current byte
	logic [7:0]  sh;                // Shift register, both directions
	logic [2:0]  ptr;               // Next register byte
	logic [1:0]  byte_idx;          // Counts the two dropped bytes
	logic        rw;                // Read transfer
	logic        ack_ok;            // Controller acked the read byte
	logic        scl_rise;
	logic        scl_fall;
	logic        bus_start;
	logic        bus_stop;
	logic [7:0]  rd_now;            // Byte to send next

	// Readback decode, shared by address ack and read ack
	function automatic logic [7:0] rd_byte(input logic [2:0] idx);
		rd_byte = (idx < PTR_END) ? regs[idx] : RD_NONE;
	endfunction

	assign scl_rise  = filt[PIN_SCL] & ~filt_q[PIN_SCL];
	assign scl_fall  = ~filt[PIN_SCL] & filt_q[PIN_SCL];
	assign bus_start = filt[PIN_SCL] & filt_q[PIN_SCL] & ~filt[PIN_SDA] & filt_q[PIN_SDA];
	assign bus_stop  = filt[PIN_SCL] & filt_q[PIN_SCL] & filt[PIN_SDA] & ~filt_q[PIN_SDA];
	assign rd_now    = rd_byte(ptr);

	// Slave receiver with readback; the data pin is only ever pulled low
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			ser_state <= SER_IDLE;
			bitc <= '0;
			sh <= '0;
			ptr <= '0;
			byte_idx <= '0;
			rw <= 1'b0;
			ack_ok <= 1'b0;
			ser_data_o <= 1'b0;
			ser_data_oe_o <= 1'b0;
			for (int i = 0; i < NUM_BYTES; i++) begin
				regs[i] <= (i == int'(REG_FUNC)) ? FUNC_RST : EN_RST;
			end
		end else if (clk_en_i) begin
			if (pd_state == PD_DOWN || bus_stop) begin
				// Pins float in power-down; contents are retained
				ser_state <= SER_IDLE;
				ser_data_oe_o <= 1'b0;
			end else if (bus_start) begin
				ser_state <= SER_ADDR;
				bitc <= '0;
				ptr <= REG_FUNC;
				byte_idx <= '0;
				ser_data_oe_o <= 1'b0;
			end else if (scl_rise) begin
				bitc <= bitc + 4'h1;
				if (ser_state == SER_RACK) begin
					ack_ok <= ~filt[PIN_SDA];
				end else if (ser_state != SER_RBYTE) begin
					sh <= {sh[6:0], filt[PIN_SDA]};
				end
			end else if (scl_fall) begin
				case (ser_state)
					SER_ADDR: begin
						if (bitc == BYTE_BITS) begin
							bitc <= '0;
							if (sh[7:1] == DEV_ADDR) begin
								ser_state <= SER_ACK;
								rw <= sh[0];
								ser_data_oe_o <= 1'b1;
							end else begin
								ser_state <= SER_IDLE;
							end
						end
					end
					SER_WBYTE: begin
						if (bitc == BYTE_BITS) begin
							bitc <= '0;
							ser_state <= SER_ACK;
							ser_data_oe_o <= 1'b1;
							if (byte_idx != SKIP_BYTES) begin
								byte_idx <= byte_idx + 2'h1;
							end else if (ptr != PTR_END) begin
								ptr <= ptr + 3'h1;
								if (ptr != REG_RSVD) begin
									regs[ptr] <= sh;
								end
							end
						end
					end
					SER_ACK: begin
						bitc <= '0;
						if (rw) begin
							ser_state <= SER_RBYTE;
							sh <= rd_now;
							ser_data_oe_o <= ~rd_now[7];
							if (ptr != PTR_END) begin
								ptr <= ptr + 3'h1;
							end
						end else begin
							ser_state <= SER_WBYTE;
							ser_data_oe_o <= 1'b0;
						end
					end
					SER_RBYTE: begin
						if (bitc == BYTE_BITS) begin
							bitc <= '0;
							ser_state <= SER_RACK;
							ser_data_oe_o <= 1'b0;
						end else begin
							sh <= {sh[6:0], 1'b0};
							ser_data_oe_o <= ~sh[6];
						end
					end
					SER_RACK: begin
						bitc <= '0;
						// The next byte must be out at this very fall, not one bit later
						if (ack_ok) begin
							ser_state <= SER_RBYTE;
							sh <= rd_now;
							ser_data_oe_o <= ~rd_now[7];
							if (ptr != PTR_END) begin
								ptr <= ptr + 3'h1;
							end
						end else begin
							// A missing ack ends the read; the stop follows
							ser_state <= SER_IDLE;
							ser_data_oe_o <= 1'b0;
						end
					end
					default: begin
						ser_state <= SER_IDLE;
					end
				endcase
			end
		end
	end

	// ****************************************************************
	// Clock generation and gating
	// ****************************************************************
	logic [7:0]  func_act;   // Function byte in force
	logic        test_mode;
	logic [1:0]  ph;         // Internal processor and bus dividers
	logic [1:0]  tdiv;       // Dividers of the test clock
	logic [1:0]  next_ph;
	logic [1:0]  next_tdiv;
	logic        cb_p;       // Processor and memory base, as now output
	logic        cb_b;       // Bus base, as now output
	logic        cb_r;       // Reference base, as now output
	logic        nb_p;
	logic        nb_b;
	logic        nb_r;
	cogp_clk_t   en_reg;     // Enables as programmed
	cogp_clk_t   live;       // Enables after halts and power-down
	cogp_clk_t   eff;        // Enables latched at low boundaries
	cogp_clk_t   next_eff;
	cogp_clk_t   next_clk;

	assign test_mode = (func_act[MODE_LSB +: 2] == MODE_TEST);
	assign next_ph   = osc_run ? ph + 2'h1 : ph;
	assign next_tdiv = (filt[PIN_XTAL] & ~filt_q[PIN_XTAL]) ? tdiv + 2'h1 : tdiv;
	assign cb_p = test_mode ? tdiv[0] : ph[0];
	assign cb_b = test_mode ? tdiv[1] : ph[1];
	assign cb_r = filt_q[PIN_XTAL];
	assign nb_p = test_mode ? next_tdiv[0] : next_ph[0];
	assign nb_b = test_mode ? next_tdiv[1] : next_ph[1];
	assign nb_r = filt[PIN_XTAL];

	// Byte to output mapping; byte 6 and reserved bits steer nothing
	assign en_reg.processor_clock_outputs = regs[REG_PROC][0 +: N_PROC];
	assign en_reg.bus_clock_outputs = regs[REG_BUS][0 +: N_BUS];
	assign en_reg.free_running_bus_clock = regs[REG_BUS][BUS_FREE_BIT];
	assign en_reg.memory_clock_outputs =
		{regs[REG_MEMH][0 +: N_MEMH], regs[REG_MEML]};
	assign en_reg.interrupt_ctrl_clock_outputs = regs[REG_PERI][INTC_LSB +: N_INTC];
	assign en_reg.reference_clock_out = regs[REG_PERI][REF_BIT];

	assign live.processor_clock_outputs = (halt_proc_act | pd_gate) ? '0 :
		en_reg.processor_clock_outputs;
	assign live.bus_clock_outputs = (halt_bus_act | pd_gate) ? '0 :
		en_reg.bus_clock_outputs;
	assign live.free_running_bus_clock = en_reg.free_running_bus_clock & ~pd_gate;
	assign live.memory_clock_outputs = pd_gate ? '0 : en_reg.memory_clock_outputs;
	assign live.interrupt_ctrl_clock_outputs = pd_gate ? '0 :
		en_reg.interrupt_ctrl_clock_outputs;
	assign live.reference_clock_out = en_reg.reference_clock_out & ~pd_gate;

	// An enable moves only while its clock is low, so pulses stay whole
	assign next_eff.processor_clock_outputs = cb_p ? eff.processor_clock_outputs :
		live.processor_clock_outputs;
	assign next_eff.memory_clock_outputs = cb_p ? eff.memory_clock_outputs :
		live.memory_clock_outputs;
	assign next_eff.bus_clock_outputs = cb_b ? eff.bus_clock_outputs :
		live.bus_clock_outputs;
	assign next_eff.free_running_bus_clock = cb_b ? eff.free_running_bus_clock :
		live.free_running_bus_clock;
	assign next_eff.interrupt_ctrl_clock_outputs = cb_r ? eff.interrupt_ctrl_clock_outputs :
		live.interrupt_ctrl_clock_outputs;
	assign next_eff.reference_clock_out = cb_r ? eff.reference_clock_out :
		live.reference_clock_out;

	assign next_clk.processor_clock_outputs = {N_PROC{nb_p}} & next_eff.processor_clock_outputs;
	assign next_clk.memory_clock_outputs = {N_MEML+N_MEMH{nb_p}} & next_eff.memory_clock_outputs;
	assign next_clk.bus_clock_outputs = {N_BUS{nb_b}} & next_eff.bus_clock_outputs;
	assign next_clk.free_running_bus_clock = nb_b & next_eff.free_running_bus_clock;
	assign next_clk.interrupt_ctrl_clock_outputs = {N_INTC{nb_r}} &
		next_eff.interrupt_ctrl_clock_outputs;
	assign next_clk.reference_clock_out = nb_r & next_eff.reference_clock_out;

	// Dividers, latched enables and output flops
	always_ff @(posedge clk_sys_i) begin
		if (sys_rst_i) begin
			ph <= '0;
			tdiv <= '0;
			eff <= '0;
			func_act <= FUNC_RST;
			clocks_o <= '0;
			clocks_oe_o <= 1'b0;
			ssc_cfg_o <= '0;
			osc_run_o <= 1'b1;
		end else if (clk_en_i) begin
			ph <= next_ph;
			tdiv <= next_tdiv;
			eff <= next_eff;
			clocks_o <= next_clk;
			osc_run_o <= osc_run;
			// Mode switches only while the divided clocks are low
			if (!cb_p && !cb_b) begin
				func_act <= regs[REG_FUNC];
			end
			clocks_oe_o <= filt[PIN_OE] && (func_act[MODE_LSB +: 2] != MODE_TRI);
			ssc_cfg_o.spread_on <= (func_act[MODE_LSB +: 2] == MODE_SSC);
			ssc_cfg_o.spread_down <= func_act[SSC_TYPE_BIT];
			ssc_cfg_o.spread_narrow <= func_act[SSC_AMT_BIT];
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	func_reset_a: assert property (@(posedge clk_sys_i)
		$fell(sys_rst_i) |-> (regs[REG_FUNC] == FUNC_RST) && (regs[REG_RSVD] == EN_RST))
		else $error("function byte not cleared at reset");

	tri_mode_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i || !clk_en_i)
		(func_act[MODE_LSB +: 2] == MODE_TRI) |=> !clocks_oe_o)
		else $error("outputs driven in tri-state mode");

	oe_pin_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i || !clk_en_i)
		!filt[PIN_OE] |=> !clocks_oe_o)
		else $error("outputs driven with enable pin low");

	spread_cfg_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i || !clk_en_i)
		clk_en_i ##1 clk_en_i |-> ssc_cfg_o.spread_down == $past(func_act[SSC_TYPE_BIT])
			&& ssc_cfg_o.spread_narrow == $past(func_act[SSC_AMT_BIT]))
		else $error("spread settings do not follow function byte");

	proc_halt_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i || !clk_en_i)
		$rose(halt_proc_act) |-> ##[1:3] (clocks_o.processor_clock_outputs == '0))
		else $error("processor clocks not halted in time");

	bus_halt_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i || !clk_en_i)
		(halt_bus_act && !pd_gate && eff.free_running_bus_clock && !test_mode)
		|-> ##[1:4] clocks_o.free_running_bus_clock)
		else $error("free bus clock stopped by bus halt");

	gate_low_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i || !clk_en_i)
		(!cb_p && !live.processor_clock_outputs[0]) |=> !clocks_o.processor_clock_outputs[0])
		else $error("disabled processor clock not held low");

	pd_stop_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i || !clk_en_i)
		(pd_state == PD_RUN && pd_req && !test_mode) |-> ##3 (clocks_o.processor_clock_outputs == '0
			&& clocks_o.bus_clock_outputs == '0 && clocks_o.memory_clock_outputs == '0) [*3])
		else $error("power-down did not stop clocks in time");

	pm_mode_a: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i || !clk_en_i)
		(filt[PIN_MODE] && pd_state == PD_RUN) |=> (pd_state == PD_RUN))
		else $error("power-down taken with management disabled");

endmodule
`default_nettype wire

/* File: common/cogp_pkg.sv */
package cogp_pkg;

	// ****************************************************************
	// Register map
	// ****************************************************************
	localparam int unsigned NUM_BYTES     = 7;     // Function byte, five enable bytes and one reserved byte
	localparam logic [2:0]  REG_FUNC      = 3'h0;  // function_select
	localparam logic [2:0]  REG_PROC      = 3'h1;  // processor_clock_enables
	localparam logic [2:0]  REG_BUS       = 3'h2;  // bus_clock_enables
	localparam logic [2:0]  REG_MEML      = 3'h3;  // memory_clock_enables_low
	localparam logic [2:0]  REG_MEMH      = 3'h4;  // memory_clock_enables_high
	localparam logic [2:0]  REG_PERI      = 3'h5;  // peripheral_clock_enables
	localparam logic [2:0]  REG_RSVD      = 3'h6;  // future_reserved, read-only ones
	localparam logic [2:0]  PTR_END       = 3'h7;  // Pointer parks here past the last byte
	localparam logic [7:0]  FUNC_RST      = 8'h00; // Function byte powers up cleared
	localparam logic [7:0]  EN_RST        = 8'hff; // Enable bytes power up all ones
	localparam logic [7:0]  RD_NONE       = 8'h00; // Read data past the last byte

	// ****************************************************************
	// Field layout
	// ****************************************************************
	localparam int unsigned MODE_LSB      = 0;     // Operating mode, two bits
	localparam int unsigned SSC_AMT_BIT   = 4;     // 0 = 1.8 %, 1 = 0.6 %
	localparam int unsigned SSC_TYPE_BIT  = 5;     // 0 = centered, 1 = down spread
	localparam int unsigned N_PROC        = 4;
	localparam int unsigned N_BUS         = 6;
	localparam int unsigned N_MEML        = 8;
	localparam int unsigned N_MEMH        = 4;
	localparam int unsigned N_INTC        = 2;
	localparam int unsigned BUS_FREE_BIT  = 6;
	localparam int unsigned INTC_LSB      = 4;
	localparam int unsigned REF_BIT       = 0;

	localparam logic [1:0]  MODE_NORMAL   = 2'h0;
	localparam logic [1:0]  MODE_TEST     = 2'h1;
	localparam logic [1:0]  MODE_SSC      = 2'h2;
	localparam logic [1:0]  MODE_TRI      = 2'h3;

	// ****************************************************************
	// Serial port and pins
	// ****************************************************************
	localparam logic [6:0]  DEV_ADDR      = 7'h69; // Write D2h, read D3h
	localparam logic [3:0]  BYTE_BITS     = 4'h8;
	localparam logic [1:0]  SKIP_BYTES    = 2'h2;  // Command and count bytes are dropped
	localparam int unsigned NUM_PINS      = 8;
	localparam int unsigned PIN_HALT_PROC = 0;
	localparam int unsigned PIN_HALT_BUS  = 1;
	localparam int unsigned PIN_PD_N      = 2;
	localparam int unsigned PIN_OE        = 3;
	localparam int unsigned PIN_MODE      = 4;
	localparam int unsigned PIN_XTAL      = 5;
	localparam int unsigned PIN_SCL       = 6;
	localparam int unsigned PIN_SDA       = 7;
	localparam logic [7:0]  PIN_RST       = 8'hdf; // Idle level of every pin

	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int unsigned SYS_CLK_MHZ   = 100;
	localparam int unsigned PROC_DIV      = 2;     // System cycles per processor cycle
	localparam int unsigned PD_STOP_CYC   = 2;     // Processor cycles to stop on power-down
	localparam int unsigned PD_DRAIN_SYS  = PD_STOP_CYC * PROC_DIV;
	localparam int unsigned PD_WAKE_US    = 3000;  // Power-up latency, 3 ms
	localparam int unsigned PD_WAKE_DEF   = PD_WAKE_US * SYS_CLK_MHZ;

	typedef enum logic [1:0] {
		PD_RUN   = 2'b00,
		PD_DRAIN = 2'b01,
		PD_DOWN  = 2'b10,
		PD_WAKE  = 2'b11
	} cogp_pd_t;

	typedef enum logic [2:0] {
		SER_IDLE  = 3'b000,
		SER_ADDR  = 3'b001,
		SER_WBYTE = 3'b010,
		SER_ACK   = 3'b011,
		SER_RBYTE = 3'b100,
		SER_RACK  = 3'b101
	} cogp_ser_t;

	typedef struct packed {
		logic [N_PROC-1:0]        processor_clock_outputs;
		logic [N_BUS-1:0]         bus_clock_outputs;
		logic                     free_running_bus_clock;
		logic [N_MEML+N_MEMH-1:0] memory_clock_outputs;
		logic [N_INTC-1:0]        interrupt_ctrl_clock_outputs;
		logic                     reference_clock_out;
	} cogp_clk_t;

	typedef struct packed {
		logic spread_on;
		logic spread_down;
		logic spread_narrow;
	} cogp_ssc_t;

endpackage

/* File: tb/cogp_ser_host.sv */
`timescale 1ns/1ps
`default_nettype none
module cogp_ser_host (
	input  wire logic sda_i,  // Data wire level
	output logic      scl_o,  // Link clock, stands high between frames
	output logic      pull_o  // High pulls the data wire low
);
	// ****
	// Serial controller model
	// ****
	initial begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end
	// 80 ns bit; the long low phase lets the filtered device answer settle
	task automatic bit_x(input logic b, output logic r);
		#20 pull_o = ~b;
		#40 scl_o = 1'b1;
		#10 r = sda_i;
		#10 scl_o = 1'b0;
	endtask
	// Data falls while the clock is high
	task automatic start();
		#20 pull_o = 1'b1;
		#20 scl_o = 1'b0;
	endtask
	// Data rises while the clock is high
	task automatic stop();
		#20 pull_o = 1'b1;
		#20 scl_o = 1'b1;
		#20 pull_o = 1'b0;
		#20;
	endtask
	// Eight bits most significant first, then the answer bit
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic r);
		for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
		bit_x(a, r);
	endtask
endmodule
`default_nettype wire

/* File: tb/clock_output_gating_pm_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module clock_output_gating_pm_tb;
	import cogp_pkg::*;
	// ****
	// Stimulus and wiring
	// ****
	localparam int WAKE = 20;      // Short power-up latency
	logic clk_sys_i = 0;
	logic sys_rst_i = 1;
	logic pm = 0, oe_pin = 1, hp_n = 1, hb_n = 1, pd_n = 1, xtal = 0;
	logic scl, pull, sda_oe, osc, oe, ak, sda_d;
	wire logic sda = ~(sda_oe | pull); // Pulled up unless someone drives
	cogp_clk_t  clk_o, any_hi, all_hi;
	cogp_ssc_t  ssc;
	logic [7:0] rb [8];
	int num_errors = 0;
	int checks_done = 0;
	int n;
	always #5 clk_sys_i = ~clk_sys_i;
	// Crystal stops while the oscillator is off
	always #33 xtal = osc ? ~xtal : 1'b0;
	cogp_ser_host h_u (.sda_i(sda), .scl_o(scl), .pull_o(pull));
	cogp_clock_gate #(.WAKE_CYC(WAKE)) dut_u (
		.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .clk_en_i(1'b1), .pm_mode_i(pm),
		.out_enable_i(oe_pin), .halt_proc_n_i(hp_n), .halt_bus_n_i(hb_n),
		.power_down_n_i(pd_n), .crystal_input_i(xtal), .ser_clk_i(scl), .ser_data_i(sda),
		.ser_data_o(sda_d), .ser_data_oe_o(sda_oe), .clocks_o(clk_o), .clocks_oe_o(oe),
		.ssc_cfg_o(ssc), .osc_run_o(osc));
	// ****
	// Tasks
	// ****
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		if (num_errors == 0 && checks_done > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic at(input int c);
		repeat (c) @(posedge clk_sys_i);
		#1;
	endtask
	// Which outputs were ever high, which always high
	task automatic watch(input int c);
		any_hi = '0;
		all_hi = '1;
		repeat (c) begin
			at(1);
			any_hi |= clk_o;
			all_hi &= clk_o;
		end
	endtask
	// Command and count bytes first, then bytes 0..2
	task automatic wr3(input logic [7:0] b0, b1, b2);
		logic [7:0] q;
		logic [7:0] d [6];
		d = '{8'hd2, 8'h00, 8'h03, b0, b1, b2};
		h_u.start();
		foreach (d[i]) h_u.xfer(d[i], 1'b1, q, ak);
		h_u.stop();
		chk(ak, 0);
		at(4);
	endtask
	task automatic rd8();
		logic [7:0] q;
		h_u.start();
		h_u.xfer(8'hd3, 1'b1, q, ak);
		for (int i = 0; i < 8; i++) h_u.xfer(8'hff, i == 7, rb[i], ak);
		h_u.stop();
		chk(sda_d, 0);
	endtask
	// ****
	// Sequence
	// ****
	initial begin
		at(16);
		sys_rst_i = 0;
		at(10);
		rd8();
		foreach (rb[i]) chk(rb[i], i == 0 ? FUNC_RST : (i == 7 ? RD_NONE : EN_RST));
		chk(rb[REG_RSVD], EN_RST);
		watch(24);
		chk(32'(any_hi & ~all_hi), 32'h3ffffff);
		chk(oe, 1);
		wr3(8'h32, 8'h0e, 8'hbf);
		chk(ssc, 3'h7);
		watch(24);
		chk(any_hi.processor_clock_outputs, 4'he);
		chk({any_hi.free_running_bus_clock, any_hi.bus_clock_outputs}, 7'h3f);
		wr3(8'h02, 8'hff, 8'hff);
		chk(ssc, 3'h4);
		wr3(8'h03, 8'hff, 8'hff);
		chk(oe, 0);
		wr3(8'h01, 8'hff, 8'hff);
		watch(40);
		chk(32'(any_hi & ~all_hi), 32'h3ffffff);
		wr3(8'h00, 8'hff, 8'hff);
		oe_pin = 0;
		at(8);
		chk(oe, 0);
		oe_pin = 1;
		hp_n = 0;
		at(12);
		watch(30);
		chk(any_hi.processor_clock_outputs, 0);
		chk(any_hi.bus_clock_outputs & ~all_hi.bus_clock_outputs, 6'h3f);
		hp_n = 1;
		at(12);
		watch(10);
		chk(any_hi.processor_clock_outputs, 4'hf);
		hb_n = 0;
		at(12);
		watch(30);
		chk({any_hi.free_running_bus_clock, any_hi.bus_clock_outputs}, 7'h40);
		hb_n = 1;
		// Halt pin stays released well over 100 system cycles
		at(140);
		pm = 1;
		hp_n = 0;
		at(12);
		watch(20);
		chk(any_hi.processor_clock_outputs, 4'hf);
		pm = 0;
		hp_n = 1;
		at(12);
		pd_n = 0;
		for (n = 0; osc && n < 30; n++) at(1);
		chk(osc, 0);
		watch(5);
		chk({any_hi.processor_clock_outputs, any_hi.bus_clock_outputs}, 0);
		chk(any_hi.memory_clock_outputs, 0);
		pd_n = 1;
		for (n = 0; !clk_o.processor_clock_outputs[0] && n < 100; n++) at(1);
		chk(n > WAKE && n < WAKE + 20, 1);
		final_report();
	end
endmodule
`default_nettype wire
